// ===== core/psir_pkg.sv
package psir_pkg;

	// ----------------------------------------
	// Register addresses on the management link
	// ----------------------------------------
	localparam logic [4:0] PSIR_ADDR_STATUS = 5'h01;
	localparam logic [4:0] PSIR_ADDR_ID_HI = 5'h02;
	localparam logic [4:0] PSIR_ADDR_ID_LO = 5'h03;

	// ----------------------------------------
	// Fixed fields of basic_status_word
	// ----------------------------------------
	localparam logic PSIR_T4_VAL = 1'b0;
	localparam logic [3:0] PSIR_CAPS_VAL = 4'hf;
	localparam logic [3:0] PSIR_RSVD_VAL = 4'h0;
	localparam logic PSIR_PRE_SKIP_VAL = 1'b1;
	localparam logic PSIR_AN_ABLE_VAL = 1'b1;
	localparam logic PSIR_EXT_CAP_VAL = 1'b1;

	// ----------------------------------------
	// Reset values of the live status bits
	// ----------------------------------------
	localparam logic PSIR_AN_DONE_RST = 1'b0;
	localparam logic PSIR_FAULT_RST = 1'b0;
	localparam logic PSIR_LINK_RST = 1'b0;
	localparam logic PSIR_JABBER_RST = 1'b0;

	// ----------------------------------------
	// Frame layout, counted in management clock periods
	// ----------------------------------------
	localparam logic [5:0] PSIR_PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] PSIR_HDR_BITS = 5'h0d;
	localparam logic [4:0] PSIR_DATA_BITS = 5'h10;
	localparam logic [4:0] PSIR_SKIP_BITS = 5'h12;
	localparam logic [1:0] PSIR_OP_READ = 2'h2;
	localparam logic [1:0] PSIR_OP_WRITE = 2'h1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic linkGood;
		logic anDone;
		logic farEndFault;
		logic partnerFault;
		logic jabber;
		logic speed10;
	} psir_cond_type;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_HDR = 7'h02,
		S_TA_RD = 7'h04,
		S_TA_WR = 7'h08,
		S_RD_DATA = 7'h10,
		S_WR_DATA = 7'h20,
		S_SKIP = 7'h40
	} psir_state_type;

endpackage : psir_pkg

// ===== core/psir_regs.sv
// How it works
// - Status bit 15 always reads 0: no four-pair 100 Mb/s mode.
// - Status bits 14 to 11 read fixed ones: 100 and 10 full/half duplex.
// - Status bits 10 to 7 read zero; the manager writes zeros there.
// - Frames work without preamble; 32 ones needed after reset or bad opcode/turnaround.
// - Bit 5 shows auto-negotiation complete, 0 otherwise, 0 after reset.
// - Bit 4 sets on remote fault and holds until status read or reset.
// - Far-end fault or partner fault notice both set the fault latch.
// - Bit 3 reads fixed 1: auto-negotiation able.
// - Bit 2 shows valid link at 10 or 100 Mb/s, 0 after reset.
// - Link failure clears bit 2; it returns only after good link and status read.
// - Bit 1 latches jabber at 10 Mb/s until status read or reset.
// - Bit 0 reads fixed 1: extended registers present.
// - The 32-bit identifier is organization id, then model, then revision.
// - First identifier word holds organization id bits 3 to 18; top two dropped.
// - The whole identifier may optionally read as zero.
// - Latched fields hold their event until read, then follow the condition.
// - Second identifier word: id bits 19-24, six-bit model, four-bit revision.
`timescale 1ns/100ps
`default_nettype none

module psir_regs #(
	parameter logic [23:0] ORG_ID = 24'h5a5a5a, // arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h01, // arbitrary value
	parameter logic [3:0] REV_NUM = 4'h0, // arbitrary value
	parameter logic ID_ZERO = 1'b0,
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	// Clock, reset and enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Serial management pins
	input wire logic mgmtClk,
	input wire logic mgmtDataIn,
	output logic mgmtDataOut,
	output logic mgmtDataOe,
	// Conditions from the link, auto-negotiation, fault, jabber and speed detectors
	input wire psir_pkg::psir_cond_type cond
);
	import psir_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic mdcMeta_reg;
	logic mdcSync_reg;
	logic mdcLast_reg;
	logic mdioMeta_reg;
	logic mdioSync_reg;
	logic mdcRise;
	logic bitIn;
	psir_state_type state_reg;
	psir_state_type state_next;
	logic [4:0] bitCnt_reg;
	logic [4:0] bitCnt_next;
	logic [5:0] preCnt_reg;
	logic preOk_reg;
	logic [11:0] hdr_reg;
	logic [12:0] hdrFull;
	logic hdrDone;
	logic hdrBad;
	logic hdrMine;
	logic rdGo;
	logic statusRead;
	logic taBad;
	logic [15:0] shift_reg;
	logic dataOut_reg;
	logic dataOe_reg;
	logic anDone_reg;
	logic faultLatch_reg;
	logic linkLatch_reg;
	logic jabLatch_reg;
	logic faultEvt;
	logic jabEvt;
	logic [15:0] statusWord;
	logic [31:0] idValue;
	logic [15:0] readWord;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Both pins share the same depth, so data stays aligned to the edge.
	// Limitation: the clock pin must hold each level four system clocks or more.
	// Clock history resets high, so a pin resting high is not taken for a rise.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mdcMeta_reg <= 1'b1;
			mdcSync_reg <= 1'b1;
			mdcLast_reg <= 1'b1;
			mdioMeta_reg <= 1'b1;
			mdioSync_reg <= 1'b1;
		end else if (clkEn) begin
			mdcMeta_reg <= mgmtClk;
			mdcSync_reg <= mdcMeta_reg;
			mdcLast_reg <= mdcSync_reg;
			mdioMeta_reg <= mgmtDataIn;
			mdioSync_reg <= mdioMeta_reg;
		end
	end

	assign mdcRise = mdcSync_reg & ~mdcLast_reg;
	assign bitIn = mdioSync_reg;

	// ----------------------------------------
	// Frame header decode
	// ----------------------------------------
	// Thirteen bits after the first start bit: start, opcode, phy, register
	assign hdrFull = {hdr_reg, bitIn};
	assign hdrDone = (state_reg == S_HDR) && mdcRise
		&& (bitCnt_reg == PSIR_HDR_BITS - 5'h01);
	// Bad start or opcode drops the frame and demands a fresh preamble
	assign hdrBad = hdrDone && (!hdrFull[12]
		|| (hdrFull[11:10] != PSIR_OP_READ && hdrFull[11:10] != PSIR_OP_WRITE));
	assign hdrMine = hdrFull[9:5] == PHY_ADDR;
	assign rdGo = hdrDone && !hdrBad && hdrMine && hdrFull[11:10] == PSIR_OP_READ;
	assign statusRead = rdGo && hdrFull[4:0] == PSIR_ADDR_STATUS;
	// Write turnaround must be one then zero
	assign taBad = (state_reg == S_TA_WR) && mdcRise
		&& ((bitCnt_reg == 5'h00 && !bitIn) || (bitCnt_reg == 5'h01 && bitIn));

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hdr_reg <= 12'h000;
		end else if (clkEn && mdcRise && state_reg == S_HDR) begin
			hdr_reg <= hdrFull[11:0];
		end
	end

	// ----------------------------------------
	// Preamble tracking
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			preCnt_reg <= 6'h00;
		end else if (clkEn && mdcRise) begin
			if (state_reg != S_IDLE || !bitIn) begin
				preCnt_reg <= 6'h00;
			// Saturates, so a long idle run never wraps into a short count
			end else if (preCnt_reg != PSIR_PREAMBLE_LEN) begin
				preCnt_reg <= preCnt_reg + 6'h01;
			end
		end
	end

	// Once seen, later frames may start straight at the start bits
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			preOk_reg <= 1'b0;
		end else if (clkEn) begin
			if (hdrBad || taBad) begin
				preOk_reg <= 1'b0;
			end else if (mdcRise && state_reg == S_IDLE && bitIn
				&& preCnt_reg == PSIR_PREAMBLE_LEN - 6'h01) begin
				preOk_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	// Counter restarts at each phase, so one small counter serves them all
	always_comb begin
		state_next = state_reg;
		bitCnt_next = bitCnt_reg + 5'h01;
		unique case (state_reg)
			S_IDLE: begin
				bitCnt_next = 5'h00;
				if (!bitIn && preOk_reg) begin
					state_next = S_HDR;
				end
			end
			S_HDR: begin
				if (hdrDone) begin
					bitCnt_next = 5'h00;
					if (hdrBad) begin
						state_next = S_IDLE;
					end else if (!hdrMine) begin
						state_next = S_SKIP;
					end else if (hdrFull[11:10] == PSIR_OP_READ) begin
						state_next = S_TA_RD;
					end else begin
						state_next = S_TA_WR;
					end
				end
			end
			S_TA_RD: begin
				if (bitCnt_reg == 5'h01) begin
					bitCnt_next = 5'h00;
					state_next = S_RD_DATA;
				end
			end
			S_TA_WR: begin
				if (taBad) begin
					state_next = S_IDLE;
				end else if (bitCnt_reg == 5'h01) begin
					bitCnt_next = 5'h00;
					state_next = S_WR_DATA;
				end
			end
			S_RD_DATA, S_WR_DATA: begin
				if (bitCnt_reg == PSIR_DATA_BITS - 5'h01) begin
					state_next = S_IDLE;
				end
			end
			// Frames for another address are timed out by count, never driven
			S_SKIP: begin
				if (bitCnt_reg == PSIR_SKIP_BITS - 5'h01) begin
					state_next = S_IDLE;
				end
			end
		endcase
	end

	// State moves only on a synchronised clock rise
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			bitCnt_reg <= 5'h00;
		end else if (clkEn && mdcRise) begin
			state_reg <= state_next;
			bitCnt_reg <= bitCnt_next;
		end
	end

	// ----------------------------------------
	// Read data driver
	// ----------------------------------------
	// Changes just after a rising edge; the manager samples on the next one.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shift_reg <= 16'h0000;
			dataOut_reg <= 1'b1;
			dataOe_reg <= 1'b0;
		end else if (clkEn && mdcRise) begin
			// Word taken at the last address bit, before read side effects act
			if (rdGo) begin
				shift_reg <= readWord;
			end else if (state_reg == S_TA_RD && bitCnt_reg == 5'h00) begin
				dataOut_reg <= 1'b0;
				dataOe_reg <= 1'b1;
			end else if (state_reg == S_TA_RD
				|| (state_reg == S_RD_DATA && bitCnt_reg != PSIR_DATA_BITS - 5'h01)) begin
				dataOut_reg <= shift_reg[15];
				shift_reg <= {shift_reg[14:0], 1'b0};
			// Release comes at the rise that samples bit zero
			end else if (state_reg == S_RD_DATA) begin
				dataOut_reg <= 1'b1;
				dataOe_reg <= 1'b0;
			end
		end
	end

	// Pins come straight from flops, free of decode glitches
	assign mgmtDataOut = dataOut_reg;
	assign mgmtDataOe = dataOe_reg;

	// ----------------------------------------
	// Live status bits
	// ----------------------------------------
	// Sets are ORed in after the read clear, so an event in the read cycle survives.
	// A level held high keeps its latch set across any number of reads
	assign faultEvt = cond.farEndFault | cond.partnerFault;
	// Jabber outside 10 Mb/s carries no meaning and is ignored
	assign jabEvt = cond.jabber & cond.speed10;

	// Completion just follows its detector, one cycle late
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			anDone_reg <= PSIR_AN_DONE_RST;
		end else if (clkEn) begin
			anDone_reg <= cond.anDone;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			faultLatch_reg <= PSIR_FAULT_RST;
		end else if (clkEn) begin
			faultLatch_reg <= faultEvt | (faultLatch_reg & ~statusRead);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			jabLatch_reg <= PSIR_JABBER_RST;
		end else if (clkEn) begin
			jabLatch_reg <= jabEvt | (jabLatch_reg & ~statusRead);
		end
	end

	// Latched low: a failure always wins, recovery waits for a status read
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			linkLatch_reg <= PSIR_LINK_RST;
		end else if (clkEn) begin
			if (!cond.linkGood) begin
				linkLatch_reg <= 1'b0;
			end else if (statusRead) begin
				linkLatch_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	assign statusWord = {
		PSIR_T4_VAL,
		PSIR_CAPS_VAL,
		PSIR_RSVD_VAL,
		PSIR_PRE_SKIP_VAL,
		anDone_reg,
		faultLatch_reg,
		PSIR_AN_ABLE_VAL,
		linkLatch_reg,
		jabLatch_reg,
		PSIR_EXT_CAP_VAL
	};

	// Zero option is for builds that carry no real identifier
	// Organization id bit 1 is ORG_ID[23]; its top two bits are dropped
	assign idValue = ID_ZERO ? 32'h00000000
		: {ORG_ID[21:0], MODEL_NUM, REV_NUM};

	// Writes are accepted and dropped, since nothing here can be written
	// Unmapped addresses read as zero; every register here is read-only
	always_comb begin
		readWord = 16'h0000;
		unique case (hdrFull[4:0])
			PSIR_ADDR_STATUS: readWord = statusWord;
			PSIR_ADDR_ID_HI: readWord = idValue[31:16];
			PSIR_ADDR_ID_LO: readWord = idValue[15:0];
			default: readWord = 16'h0000;
		endcase
	end

endmodule : psir_regs

`default_nettype wire

// ===== tb/psir_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module psir_regs_chk
	import psir_pkg::*;
#(
	parameter logic [23:0] ORG_ID = 24'h5a5a5a, // arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h01, // arbitrary value
	parameter logic [3:0] REV_NUM = 4'h0, // arbitrary value
	parameter logic ID_ZERO = 1'b0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Management pins
	input wire logic mgmtClk,
	input wire logic mgmtDataIn,
	input wire logic mgmtDataOut,
	input wire logic mgmtDataOe
);
	localparam logic [15:0] FIX_VAL = 16'h7849;
	localparam logic [15:0] FIX_MASK = 16'hffc9;
	logic mdcReg, oeReg, mdcRise, bitSlot;
	logic [7:0] riseHist;
	logic [6:0] inHist;
	logic [4:0] rdAddr, oeCnt;
	logic [3:0] idx;
	logic [15:0] idHi, idLo;
	assign mdcRise = mgmtClk && !mdcReg;
	assign bitSlot = mdcRise && mgmtDataOe && oeCnt != 5'h00 && oeCnt < 5'h11;
	assign idx = 4'h0 - oeCnt[3:0];
	assign idHi = ID_ZERO ? 16'h0000 : ORG_ID[21:6];
	assign idLo = ID_ZERO ? 16'h0000 : {ORG_ID[5:0], MODEL_NUM, REV_NUM};
	always_ff @(posedge sys_clk) begin
		mdcReg <= mgmtClk;
		oeReg <= mgmtDataOe;
		riseHist <= {riseHist[6:0], mdcRise};
	end
	// Drive starts one rise after the address, so one turnaround bit is in
	always_ff @(posedge sys_clk) begin
		if (mdcRise) begin
			inHist <= {inHist[5:0], mgmtDataIn};
		end
		if (mgmtDataOe && !oeReg) begin
			rdAddr <= inHist[5:1];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !mgmtDataOe) begin
			oeCnt <= 5'h00;
		end else if (mdcRise) begin
			oeCnt <= oeCnt + 5'h01;
		end
	end
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> mgmtDataOut && !mgmtDataOe)
		else $error("pin driven in reset");
	idle_high_a: assert property (!mgmtDataOe |-> mgmtDataOut)
		else $error("released pin not high");
	ta_low_a: assert property ($rose(mgmtDataOe) |-> !mgmtDataOut)
		else $error("turnaround not low");
	oe_len_a: assert property ($fell(mgmtDataOe) |-> oeCnt == 5'h11)
		else $error("read drive length wrong");
	out_sync_a: assert property ($changed(mgmtDataOut) |-> |riseHist)
		else $error("pin moved off clock rise");
	status_fix_a: assert property (bitSlot && rdAddr == PSIR_ADDR_STATUS
		&& FIX_MASK[idx] |-> mgmtDataOut == FIX_VAL[idx])
		else $error("fixed status bit wrong");
	id_hi_a: assert property (bitSlot && rdAddr == PSIR_ADDR_ID_HI
		|-> mgmtDataOut == idHi[idx])
		else $error("first id word wrong");
	id_lo_a: assert property (bitSlot && rdAddr == PSIR_ADDR_ID_LO
		|-> mgmtDataOut == idLo[idx])
		else $error("second id word wrong");
	cover property (bitSlot && rdAddr == PSIR_ADDR_STATUS);
	cover property (bitSlot && rdAddr == PSIR_ADDR_ID_LO);
	cover property ($fell(mgmtDataOe));
	cover property (bitSlot && rdAddr == PSIR_ADDR_ID_HI);
endmodule : psir_regs_chk
`default_nettype wire

// ===== tb/psir_mgr.sv
`timescale 1ns/100ps
`default_nettype none
module psir_mgr (
	// Pacing clock
	input wire logic sys_clk,
	// Management pins
	output logic mdc,
	output logic mdOut,
	output logic mdOe,
	input wire logic mdPin,
	// Read result
	output logic rdValid,
	output logic [15:0] rdData
);
	import psir_pkg::*;
	initial begin
		mdc = 1'b0;
		mdOut = 1'b1;
		mdOe = 1'b0;
		rdValid = 1'b0;
		rdData = 16'h0000;
	end
	// Five system clocks a half period, above the pin sync limit
	task automatic bitx(input logic drv, input logic b, output logic s);
		@(negedge sys_clk);
		mdc = 1'b0;
		mdOe = drv;
		mdOut = b;
		repeat (5) @(negedge sys_clk);
		mdc = 1'b1;
		s = mdPin;
		repeat (4) @(negedge sys_clk);
	endtask : bitx
	task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd);
		logic [13:0] hdr;
		logic s;
		hdr = {2'b01, op, phy, ra};
		for (int i = 0; i < 32 && pre; i++) begin
			bitx(1'b1, 1'b1, s);
		end
		for (int i = 13; i >= 0; i--) begin
			bitx(1'b1, hdr[i], s);
		end
		if (op == PSIR_OP_WRITE) begin
			bitx(1'b1, 1'b1, s);
			bitx(1'b1, 1'b0, s);
			for (int i = 15; i >= 0; i--) begin
				bitx(1'b1, wd[i], s);
			end
		end else begin
			// Released from turnaround on: two turnaround rises, then data
			for (int i = 17; i >= 0; i--) begin
				bitx(1'b0, 1'b1, s);
				if (i < 16) begin
					rdData[i] = s;
				end
			end
			rdValid = 1'b1;
			@(negedge sys_clk);
			rdValid = 1'b0;
		end
		@(negedge sys_clk);
		mdOe = 1'b0;
		mdOut = 1'b1;
	endtask : frame
endmodule : psir_mgr
`default_nettype wire

// ===== tb/psir_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module psir_regs_bench;
	import psir_pkg::*;
	localparam logic [23:0] ORG_ID = 24'h3c96a5; // arbitrary value
	localparam logic [5:0] MODEL_NUM = 6'h2b; // arbitrary value
	localparam logic [3:0] REV_NUM = 4'h7; // arbitrary value
	localparam logic [4:0] ADR = 5'h01;
	localparam logic [4:0] SREG = PSIR_ADDR_STATUS;
	localparam logic [1:0] OPR = PSIR_OP_READ;
	logic sys_clk, sys_rst, clkEn, mdc, mdOut, mdOe, devOut, devOe, mdPin, rdValid;
	logic [15:0] rdData, want;
	logic [15:0] expQ[$];
	psir_cond_type cond;
	int errCount, checkCount, cycles, seed;
	// Pull-up on the shared data line
	assign mdPin = devOe ? devOut : (mdOe ? mdOut : 1'b1);
	psir_regs #(.ORG_ID(ORG_ID), .MODEL_NUM(MODEL_NUM), .REV_NUM(REV_NUM), .PHY_ADDR(ADR)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .mgmtClk(mdc), .mgmtDataIn(mdPin),
		.mgmtDataOut(devOut), .mgmtDataOe(devOe), .cond(cond));
	psir_mgr mgr (.sys_clk(sys_clk), .mdc(mdc), .mdOut(mdOut), .mdOe(mdOe), .mdPin(mdPin),
		.rdValid(rdValid), .rdData(rdData));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] st(input logic [3:0] v);
		return {1'b0, 4'hf, 4'h0, 1'b1, v[3], v[2], 1'b1, v[1], v[0], 1'b1};
	endfunction : st
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stopTest();
		$display("Checks %0d, mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stopTest
	task automatic rd(input logic pre, input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] w);
		expQ.push_back(w);
		mgr.frame(pre, op, phy, ra, 16'h0000);
	endtask : rd
	always @(posedge sys_clk) begin
		if (rdValid === 1'b1) begin
			want = expQ.pop_front();
			check(rdData, want);
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errCount++;
			stopTest();
		end
	end
	initial begin
		seed = 52430;
		sys_rst = 1'b1;
		clkEn = 1'b1;
		cond = '0;
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		rd(1'b1, OPR, ADR, SREG, st(4'h0));
		rd(1'b0, OPR, ADR, PSIR_ADDR_ID_HI, ORG_ID[21:6]);
		rd(1'b0, OPR, ADR, PSIR_ADDR_ID_LO, {ORG_ID[5:0], MODEL_NUM, REV_NUM});
		rd(1'b0, OPR, ADR, 5'h1f, 16'h0000);
		$display("Test fixed bits and identifier done");
		for (int k = 0; k < 4; k++) begin
			cond.farEndFault = (k == 0);
			cond.partnerFault = (k == 1);
			cond.jabber = (k > 1);
			cond.speed10 = (k == 2);
			repeat (3) @(negedge sys_clk);
			cond = '0;
			rd(1'b0, OPR, ADR, SREG, st({1'b0, k < 2, 1'b0, k == 2}));
			rd(1'b0, OPR, ADR, SREG, st(4'h0));
		end
		$display("Test latched events done");
		for (int k = 0; k < 2; k++) begin
			cond.linkGood = 1'b0;
			repeat (2) @(negedge sys_clk);
			cond.linkGood = 1'b1;
			rd(1'b0, OPR, ADR, SREG, st(4'h0));
			rd(1'b0, OPR, ADR, SREG, st(4'h2));
		end
		for (int k = 0; k < 6; k++) begin
			cond.anDone = 1'($random(seed));
			rd(1'b0, OPR, ADR, SREG, st({cond.anDone, 3'h2}));
		end
		cond.anDone = 1'b0;
		clkEn = 1'b0;
		cond.farEndFault = 1'b1;
		repeat (3) @(negedge sys_clk);
		cond.farEndFault = 1'b0;
		clkEn = 1'b1;
		rd(1'b0, OPR, ADR, SREG, st(4'h2));
		$display("Test link and completion done");
		mgr.frame(1'b0, PSIR_OP_WRITE, ADR, SREG, 16'hf87f);
		rd(1'b0, OPR, ADR, SREG, st(4'h2));
		rd(1'b0, OPR, 5'h1e, SREG, 16'hffff);
		for (int k = 0; k < 2; k++) begin
			rd(1'b0, 2'(3 * k), ADR, SREG, 16'hffff);
			rd(1'b0, OPR, ADR, SREG, 16'hffff);
			rd(1'b1, OPR, ADR, SREG, st(4'h2));
		end
		$display("Test refused frames done");
		cond.farEndFault = 1'b1;
		cond.jabber = 1'b1;
		cond.speed10 = 1'b1;
		repeat (3) @(negedge sys_clk);
		cond = '0;
		sys_rst = 1'b1;
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		rd(1'b0, OPR, ADR, SREG, 16'hffff);
		rd(1'b1, OPR, ADR, SREG, st(4'h0));
		$display("Test mid-run reset done");
		repeat (4) @(negedge sys_clk);
		check(16'(expQ.size()), 16'h0000);
		stopTest();
	end
endmodule : psir_regs_bench
bind psir_regs psir_regs_chk #(.ORG_ID(ORG_ID), .MODEL_NUM(MODEL_NUM), .REV_NUM(REV_NUM),
	.ID_ZERO(ID_ZERO)) chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .mgmtClk(mgmtClk),
	.mgmtDataIn(mgmtDataIn), .mgmtDataOut(mgmtDataOut), .mgmtDataOe(mgmtDataOe));
`default_nettype wire
